// file: hw/pafs_params.svh
`ifndef PAFS_PARAMS_SVH
`define PAFS_PARAMS_SVH

`define PAFS_ADDR_DEVICE_IDENTITY  8'h3e
`define PAFS_ADDR_AUX_PWM_FREQUENCY 8'h3f
`define PAFS_AUX_FREQ_RESET        8'h00
`define PAFS_AUX_CODE_MSB          5
`define PAFS_AUX_CODE_LSB          0
`define PAFS_AUX_RSVD_MSB          7
`define PAFS_AUX_RSVD_LSB          6
`define PAFS_UNMAPPED_READ         8'h00
`define PAFS_PERIOD_BASE           11'h400
`define PAFS_PERIOD_STEP           11'h020
`define PAFS_PERIOD_STEP_TOP       11'h008
`define PAFS_TOP_SEG_LAST_IDX      4'h6
`define PAFS_PERIOD_MIN            11'h050
`define PAFS_PWM_COUNT             7

`endif

// file: hw/pafs_pkg.sv
`default_nettype none
`include "pafs_params.svh"

package pafs_pkg;

  typedef struct packed {
    logic [10:0] rise;
    logic [10:0] fall;
  } pafs_edge_t;

  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
    logic       rd;
    logic [7:0] wrData;
  } pafs_reg_req_t;

  // switching period in clk cycles for an auxiliary frequency code
  function automatic logic [10:0] pafs_aux_period(input logic [5:0] code);
    logic [1:0]  seg;
    logic [3:0]  idx;
    logic [10:0] step;
    seg = code[5:4];
    idx = code[3:0];
    if (seg == 2'h3 && idx > `PAFS_TOP_SEG_LAST_IDX) begin
      idx = `PAFS_TOP_SEG_LAST_IDX;
    end
    step = (seg == 2'h3) ? `PAFS_PERIOD_STEP_TOP : (`PAFS_PERIOD_STEP >> seg);
    return 11'((`PAFS_PERIOD_BASE >> seg) - 11'(step * {7'h00, idx}));
  endfunction

endpackage

`default_nettype wire

// file: hw/pafs_pwm_gen.sv
`timescale 1ns/1ns
`default_nettype none

module pafs_pwm_gen #(
  parameter int W = 11
) (
  input  wire logic         clk,
  input  wire logic         rstn,
  input  wire logic [W-1:0] period,
  input  wire logic [W-1:0] rise,
  input  wire logic [W-1:0] fall,
  output logic              pwmOut,
  output logic              wrapPulse
);

  logic [W-1:0] cnt_reg;
  logic [W-1:0] cnt_next;
  logic [W-1:0] per_reg;
  logic [W-1:0] per_next;
  logic         out_reg;
  logic         out_next;
  logic         wrap;

  // new period is taken only at the frame wrap
  always_comb begin
    wrap     = (cnt_reg >= per_reg - W'(1));
    cnt_next = wrap ? '0 : cnt_reg + W'(1);
    per_next = wrap ? period : per_reg;
    out_next = (cnt_next >= rise) && (cnt_next < fall);
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_reg <= '0;
      per_reg <= '1;
      out_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      per_reg <= per_next;
      out_reg <= out_next;
    end
  end

  assign pwmOut    = out_reg;
  assign wrapPulse = wrap;

  AST_PWM_EDGE: assert property (@(posedge clk) disable iff (!rstn)
    $past(rstn) && $stable(rise) && $stable(fall) |->
    pwmOut == ((cnt_reg >= rise) && (cnt_reg < fall)))
    else $error("pwm output disagrees with its edge settings");

  AST_PWM_WRAP: assert property (@(posedge clk) disable iff (!rstn)
    wrap && per_reg != '0 |=> cnt_reg == '0 ##1 cnt_reg == W'(1) || $past(per_reg) == W'(1))
    else $error("pwm counter did not restart after wrap");

endmodule // pafs_pwm_gen

`default_nettype wire

// file: hw/pafs_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "pafs_params.svh"

module pafs_top #(
  parameter logic [7:0] DEVICE_IDENTITY = 8'h5a  // arbitrary value
) (
  input  wire logic                          clk,
  input  wire logic                          rstn,
  input  wire pafs_pkg::pafs_reg_req_t       regReq,
  output logic [7:0]                         regRdData,
  input  wire logic [10:0]                   mainPeriod,
  input  wire pafs_pkg::pafs_edge_t [5:0]    mainEdge,
  input  wire pafs_pkg::pafs_edge_t          auxEdge,
  output logic [5:0]                         mainPwm,
  output logic                               auxiliaryPwmOutput,
  output logic                               frameStart
);

  logic [7:0]  auxFreq_reg;
  logic [7:0]  auxFreq_next;
  logic [7:0]  rdData_reg;
  logic [7:0]  rdData_next;
  logic [10:0] auxPeriod;
  logic [5:0]  mainWrap;
  logic        isIdAddr;
  logic        isAuxAddr;

  // register decode and read mux
  always_comb begin
    isIdAddr     = (regReq.addr == `PAFS_ADDR_DEVICE_IDENTITY);
    isAuxAddr    = (regReq.addr == `PAFS_ADDR_AUX_PWM_FREQUENCY);
    auxFreq_next = auxFreq_reg;
    rdData_next  = rdData_reg;
    if (regReq.wr && isAuxAddr) begin
      auxFreq_next = regReq.wrData;
    end
    if (regReq.rd) begin
      if (isIdAddr) begin
        rdData_next = DEVICE_IDENTITY;
      end else if (isAuxAddr) begin
        rdData_next = auxFreq_reg;
      end else begin
        rdData_next = `PAFS_UNMAPPED_READ;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      auxFreq_reg <= `PAFS_AUX_FREQ_RESET;
      rdData_reg  <= 8'h00;
    end else begin
      auxFreq_reg <= auxFreq_next;
      rdData_reg  <= rdData_next;
    end
  end

  assign regRdData = rdData_reg;

  // only the low six bits steer the auxiliary period
  assign auxPeriod =
    pafs_pkg::pafs_aux_period(auxFreq_reg[`PAFS_AUX_CODE_MSB:`PAFS_AUX_CODE_LSB]);

  // six outputs on the main frame, edges from the timing group
  for (genvar i = 0; i < `PAFS_PWM_COUNT - 1; i++) begin : gMain
    pafs_pwm_gen #(.W(11)) uGen (
      .clk       (clk),
      .rstn      (rstn),
      .period    (mainPeriod),
      .rise      (mainEdge[i].rise),
      .fall      (mainEdge[i].fall),
      .pwmOut    (mainPwm[i]),
      .wrapPulse (mainWrap[i])
    );
  end

  pafs_pwm_gen #(.W(11)) uAux (
    .clk       (clk),
    .rstn      (rstn),
    .period    (auxPeriod),
    .rise      (auxEdge.rise),
    .fall      (auxEdge.fall),
    .pwmOut    (auxiliaryPwmOutput),
    .wrapPulse ()
  );

  // reference edge of the main frame
  assign frameStart = mainWrap[0];

  AST_ID_READ: assert property (@(posedge clk) disable iff (!rstn)
    regReq.rd && regReq.addr == `PAFS_ADDR_DEVICE_IDENTITY |=> regRdData == DEVICE_IDENTITY)
    else $error("identification read returned wrong value");

  AST_ID_AFTER_WRITE: assert property (@(posedge clk) disable iff (!rstn)
    regReq.wr && regReq.addr == `PAFS_ADDR_DEVICE_IDENTITY ##1
    regReq.rd && regReq.addr == `PAFS_ADDR_DEVICE_IDENTITY |=> regRdData == DEVICE_IDENTITY)
    else $error("identification changed after write");

  AST_AUX_PERIOD: assert property (@(posedge clk) disable iff (!rstn)
    regReq.wr && regReq.addr == `PAFS_ADDR_AUX_PWM_FREQUENCY |=>
    auxPeriod == pafs_pkg::pafs_aux_period($past(regReq.wrData[5:0])))
    else $error("auxiliary period does not follow written code");

  AST_AUX_RANGE: assert property (@(posedge clk) disable iff (!rstn)
    auxPeriod <= `PAFS_PERIOD_BASE && auxPeriod >= `PAFS_PERIOD_MIN)
    else $error("auxiliary period outside table range");

  AST_AUX_MONO: assert property (@(posedge clk) disable iff (!rstn)
    regReq.wr && regReq.addr == `PAFS_ADDR_AUX_PWM_FREQUENCY &&
    regReq.wrData[5:0] > auxFreq_reg[5:0] && auxFreq_reg[5:0] < 6'h36 |=>
    auxPeriod < $past(auxPeriod))
    else $error("higher code did not shorten the period");

  AST_RSVD_HOLD: assert property (@(posedge clk) disable iff (!rstn)
    regReq.wr && regReq.addr == `PAFS_ADDR_AUX_PWM_FREQUENCY ##1
    regReq.rd && regReq.addr == `PAFS_ADDR_AUX_PWM_FREQUENCY && !regReq.wr |=>
    regRdData == $past(regReq.wrData, 2))
    else $error("auxiliary register readback mismatch");

  AST_RD_STANDS: assert property (@(posedge clk) disable iff (!rstn)
    !regReq.rd |=> $stable(regRdData))
    else $error("read data changed without a read");

  AST_UNMAPPED_READ: assert property (@(posedge clk) disable iff (!rstn)
    regReq.rd && regReq.addr != `PAFS_ADDR_DEVICE_IDENTITY &&
    regReq.addr != `PAFS_ADDR_AUX_PWM_FREQUENCY |=> regRdData == `PAFS_UNMAPPED_READ)
    else $error("unmapped read returned nonzero data");

endmodule // pafs_top

`default_nettype wire

// file: test/pafs_drv_model.sv
`timescale 1ns/1ns
`default_nettype none
module pafs_drv_model (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic [5:0]  mainPwm,
  input  wire logic        auxPwm,
  output logic [11:0]      auxPeriod,
  output logic             auxRise,
  output logic [6:0]       seen
);
  logic [11:0] cnt;
  logic        auxLast;
  // interval between aux rising edges, outputs that ever switched on
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt       <= 12'h000;
      auxLast   <= 1'b0;
      auxPeriod <= 12'h000;
      auxRise   <= 1'b0;
      seen      <= 7'h00;
    end else begin
      auxLast <= auxPwm;
      seen    <= seen | {auxPwm, mainPwm};
      auxRise <= auxPwm & ~auxLast;
      cnt     <= (auxPwm & ~auxLast) ? 12'h001 : cnt + 12'h001;
      if (auxPwm & ~auxLast) begin
        auxPeriod <= cnt;
      end
    end
  end
endmodule // pafs_drv_model
`default_nettype wire

// file: test/testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
  localparam logic [7:0] ID = 8'h96;  // arbitrary value
  logic clk, rstn, auxPwm, frameStart, auxRise;
  logic [7:0] regRdData;
  logic [10:0] mainPeriod;
  logic [5:0] mainPwm;
  logic [6:0] seen;
  logic [11:0] auxPeriod;
  pafs_pkg::pafs_reg_req_t regReq;
  pafs_pkg::pafs_edge_t [5:0] mainEdge;
  pafs_pkg::pafs_edge_t auxEdge;
  int miscompares, checksDone;
  pafs_top #(.DEVICE_IDENTITY(ID)) u_dut (.clk(clk), .rstn(rstn), .regReq(regReq),
    .regRdData(regRdData), .mainPeriod(mainPeriod), .mainEdge(mainEdge), .auxEdge(auxEdge),
    .mainPwm(mainPwm), .auxiliaryPwmOutput(auxPwm), .frameStart(frameStart));
  pafs_drv_model u_drv (.clk(clk), .rstn(rstn), .mainPwm(mainPwm), .auxPwm(auxPwm),
    .auxPeriod(auxPeriod), .auxRise(auxRise), .seen(seen));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  function automatic logic [11:0] expPer(input logic [5:0] c);
    logic [3:0] i;
    i = (c[5:4] == 2'h3 && c[3:0] > 4'h6) ? 4'h6 : c[3:0];
    if (c[5:4] == 2'h3) return 12'h080 - 12'h008 * i;
    return (12'h400 >> c[5:4]) - (12'h020 >> c[5:4]) * i;
  endfunction
  task chk(input string n, input logic [11:0] e, input logic [11:0] g);
    checksDone++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    regReq = '{addr: a, wr: 1'b1, rd: 1'b0, wrData: d};
    @(negedge clk);
    regReq.wr = 1'b0;
  endtask
  task rdChk(input string n, input logic [7:0] a, input logic [7:0] e);
    @(negedge clk);
    regReq.addr = a;
    regReq.rd = 1'b1;
    @(negedge clk);
    regReq.rd = 1'b0;
    chk(n, {4'h0, e}, {4'h0, regRdData});
  endtask
  task wrRd(input string n, input logic [7:0] a, input logic [7:0] d, input logic [7:0] e);
    @(negedge clk);
    regReq = '{addr: a, wr: 1'b1, rd: 1'b0, wrData: d};
    @(negedge clk);
    regReq = '{addr: a, wr: 1'b0, rd: 1'b1, wrData: d};
    @(negedge clk);
    regReq.rd = 1'b0;
    chk(n, {4'h0, e}, {4'h0, regRdData});
  endtask
  task frameChk;
    int n;
    n = 0;
    while (!frameStart && n < 2200) begin
      @(negedge clk);
      n++;
    end
    @(negedge clk);
    chk("main edge at frame start", 12'h001, {11'h000, mainPwm[0]});
    n = 0;
    while (!frameStart && n < 2200) begin
      @(negedge clk);
      n++;
    end
    chk("main frame length", {1'b0, mainPeriod}, 12'(n + 1));
  endtask
  task waitRise;
    for (int k = 0; k < 2200 && !auxRise; k++) @(negedge clk);
    chk("aux edge seen", 12'h001, {11'h000, auxRise});
    @(negedge clk);
  endtask
  task conclude;
    $display("checks %0d mismatches %0d", checksDone, miscompares);
    if (miscompares == 0 && checksDone > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    #(90000 * 20);
    miscompares++;
    conclude;
  end
  initial begin
    logic [7:0] codes [8];
    rstn = 1'b0;
    regReq = '0;
    mainPeriod = 11'h040;
    auxEdge = '{rise: 11'h001, fall: 11'h005};
    for (int j = 0; j < 6; j++) mainEdge[j] = '{rise: 11'(j), fall: 11'(j + 8)};
    codes = '{8'h00, 8'h4f, 8'h90, 8'hf6, 8'h3f, 8'h00, 8'h00, 8'h00};
    void'($urandom(97));
    for (int j = 5; j < 8; j++) codes[j] = 8'($urandom_range(0, 255));
    repeat (10) @(negedge clk);
    rstn = 1'b1;
    rdChk("aux reset", 8'h3f, 8'h00);
    rdChk("identity", 8'h3e, ID);
    wr(8'h3e, 8'hff);
    rdChk("identity after write", 8'h3e, ID);
    wrRd("identity write then read", 8'h3e, 8'h5c, ID);
    rdChk("unmapped", 8'h10, 8'h00);
    wr(8'h3f, 8'hc5);
    rdChk("aux walk readback", 8'h3f, 8'hc5);
    foreach (codes[j]) begin
      wrRd("aux readback", 8'h3f, codes[j], codes[j]);
      repeat (3) waitRise;
      chk("aux period", expPer(codes[j][5:0]), auxPeriod);
    end
    frameChk;
    chk("outputs active", 12'h07f, {5'h00, seen});
    rstn = 1'b0;
    repeat (2) @(negedge clk);
    rstn = 1'b1;
    rdChk("identity after reset", 8'h3e, ID);
    rdChk("aux after reset", 8'h3f, 8'h00);
    conclude;
  end
endmodule // testbench
`default_nettype wire
